// ===== hw/cas_pkg.sv
// Purpose: Shared constants and carriers for the atomic compare-and-swap unit
// Assumes: 64-bit registers, 32-bit APB register bus
// Notes:   Offsets are byte addresses on the APB side
package cas_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] OFF_STATUS   = 8'h00;
    localparam logic [7:0] OFF_MASK     = 8'h04;
    localparam logic [7:0] OFF_LAST_EXC = 8'h08;
    localparam logic [7:0] OFF_COUNT    = 8'h0c;
    localparam logic [7:0] OFF_SPACE_LO = 8'h10; // 8 words, one bit per space id
    localparam logic [7:0] OFF_SPACE_HI = 8'h2c;

    // Status and mask bit positions
    localparam int ST_DONE    = 0;
    localparam int ST_EXC     = 1;
    localparam int ST_MEM_ERR = 2;
    localparam int ST_W       = 3;

    localparam logic [ST_W-1:0] MASK_RESET  = 3'h0;
    localparam logic [31:0]     SPACE_RESET = 32'h0000_0000;

    // Instruction field positions
    localparam int INS_IMM_SEL = 13;
    localparam int INS_SPC_HI  = 12;
    localparam int INS_SPC_LO  = 5;

    // Privileged space window
    localparam logic [7:0] SPC_PRIV_LO = 8'h30;
    localparam logic [7:0] SPC_PRIV_HI = 8'h7f;
    localparam int         SPC_USER_BIT = 7;

    // Exception codes
    typedef enum logic [2:0] {
        EXC_NONE,
        EXC_ILLEGAL,
        EXC_MISALIGN,
        EXC_PRIV_ACTION,
        EXC_DATA_ACCESS,
        EXC_MEM_ERROR
    } exc_t;

    // Request from the issue stage
    typedef struct packed {
        logic        dword;
        logic [31:0] instr;
        logic [63:0] addr;
        logic [63:0] cmp;
        logic [63:0] swap;
        logic [7:0]  space_reg;
        logic        priv;
        logic        hpriv;
    } cas_req_t;

    // Memory request to the load-store path
    typedef struct packed {
        logic        write;
        logic        lock;
        logic        dword;
        logic [7:0]  space;
        logic [63:0] addr;
        logic [63:0] wdata;
    } mem_req_t;

endpackage : cas_pkg

// ===== hw/cas_unit.sv
// Purpose: Atomic compare-and-swap execution, word and doubleword forms
// Assumes: Memory honours the lock flag between the read and the write
// Notes:   APB slave for status, mask, permitted-space table
`timescale 1ns/1ps
`default_nettype none
module cas_unit
    import cas_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RST_B,
    // Issue side
    input  wire logic        REQ_VALID,
    input  wire cas_req_t    REQ,
    output var  logic        REQ_READY,
    // Result side
    output var  logic        RES_VALID,
    output var  logic [63:0] RES_DATA,
    output var  logic        RES_WRITE_RD,
    output var  logic        RES_WRITE_CC,
    output var  exc_t        RES_EXC,
    output var  logic        IRQ_BLOCK,
    // Memory side
    output var  logic        MEM_VALID,
    output var  mem_req_t    MEM_REQ,
    input  wire logic        MEM_READY,
    input  wire logic        MEM_DONE,
    input  wire logic [63:0] MEM_RDATA,
    input  wire logic        MEM_ERR,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output var  logic [31:0] PRDATA,
    output var  logic        PREADY,
    output var  logic        PSLVERR,
    output var  logic        IRQ
);

    // ************************************************************
    // State
    // ************************************************************
    typedef enum logic [2:0] {S_IDLE, S_CHECK, S_READ, S_WAIT_RD, S_WRITE, S_WAIT_WR,
                              S_DONE} state_t;
    state_t      state;
    cas_req_t    cur;
    logic [63:0] old_val;
    logic [31:0] space_tab [8];
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic [31:0] op_count;
    exc_t        last_exc;

    // ************************************************************
    // Decode and checks
    // ************************************************************
    logic [7:0]  sel_space;
    logic        chk_illegal;
    logic        chk_misalign;
    logic        chk_priv;
    logic        chk_space;
    logic        match;
    logic [63:0] store_val;
    exc_t        next_exc;

    always_comb begin
        // Immediate field when the select bit is clear
        sel_space = cur.instr[INS_IMM_SEL] ? cur.space_reg
                                           : cur.instr[INS_SPC_HI:INS_SPC_LO];
        chk_illegal = cur.instr[INS_IMM_SEL] &&
                      (cur.instr[INS_SPC_HI:INS_SPC_LO] != 8'h00);
        chk_misalign = cur.dword ? (cur.addr[2:0] != 3'h0)
                                 : (cur.addr[1:0] != 2'h0);
        chk_priv = 1'b0;
        if (!cur.priv && !cur.hpriv) begin
            chk_priv = !sel_space[SPC_USER_BIT];
        end else if (cur.priv && !cur.hpriv) begin
            chk_priv = (sel_space >= SPC_PRIV_LO) && (sel_space <= SPC_PRIV_HI);
        end
        chk_space = !space_tab[sel_space[7:5]][sel_space[4:0]];
        if (chk_illegal) begin
            next_exc = EXC_ILLEGAL;
        end else if (chk_misalign) begin
            next_exc = EXC_MISALIGN;
        end else if (chk_priv) begin
            next_exc = EXC_PRIV_ACTION;
        end else if (chk_space) begin
            next_exc = EXC_DATA_ACCESS;
        end else begin
            next_exc = EXC_NONE;
        end
        match = cur.dword ? (old_val == cur.cmp)
                          : (old_val[31:0] == cur.cmp[31:0]);
        // Mismatch writes the old value back so permission is always checked
        if (match) begin
            store_val = cur.dword ? cur.swap : {32'h0000_0000, cur.swap[31:0]};
        end else begin
            store_val = old_val;
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            state        <= S_IDLE;
            cur          <= '0;
            old_val      <= 64'h0;
            REQ_READY    <= 1'b0;
            RES_VALID    <= 1'b0;
            RES_DATA     <= 64'h0;
            RES_WRITE_RD <= 1'b0;
            RES_WRITE_CC <= 1'b0;
            RES_EXC      <= EXC_NONE;
            IRQ_BLOCK    <= 1'b0;
            MEM_VALID    <= 1'b0;
            MEM_REQ      <= '0;
        end else begin
            RES_VALID    <= 1'b0;
            RES_WRITE_CC <= 1'b0;
            case (state)
                S_IDLE: begin
                    REQ_READY <= 1'b1;
                    IRQ_BLOCK <= 1'b0;
                    if (REQ_VALID && REQ_READY) begin
                        cur       <= REQ;
                        REQ_READY <= 1'b0;
                        IRQ_BLOCK <= 1'b1;
                        state     <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    if (next_exc != EXC_NONE) begin
                        RES_VALID    <= 1'b1;
                        RES_EXC      <= next_exc;
                        RES_WRITE_RD <= 1'b0;
                        state        <= S_DONE;
                    end else begin
                        MEM_VALID <= 1'b1;
                        MEM_REQ   <= '{write: 1'b0, lock: 1'b1, dword: cur.dword,
                                       space: sel_space, addr: cur.addr, wdata: 64'h0};
                        state     <= S_READ;
                    end
                end
                S_READ: begin
                    if (MEM_READY) begin
                        MEM_VALID <= 1'b0;
                        state     <= S_WAIT_RD;
                    end
                end
                S_WAIT_RD: begin
                    if (MEM_DONE) begin
                        if (MEM_ERR) begin
                            MEM_REQ.lock <= 1'b0;
                            RES_VALID    <= 1'b1;
                            RES_EXC      <= EXC_MEM_ERROR;
                            RES_WRITE_RD <= 1'b0;
                            state        <= S_DONE;
                        end else begin
                            old_val <= cur.dword ? MEM_RDATA
                                                 : {32'h0000_0000, MEM_RDATA[31:0]};
                            state   <= S_WRITE;
                        end
                    end
                end
                S_WRITE: begin
                    // Lock held from read to write, memory keeps others out
                    MEM_VALID <= 1'b1;
                    MEM_REQ   <= '{write: 1'b1, lock: 1'b1, dword: cur.dword,
                                   space: sel_space, addr: cur.addr, wdata: store_val};
                    if (MEM_VALID && MEM_READY) begin
                        MEM_VALID <= 1'b0;
                        state     <= S_WAIT_WR;
                    end
                end
                S_WAIT_WR: begin
                    if (MEM_DONE) begin
                        MEM_REQ.lock <= 1'b0;
                        RES_VALID    <= 1'b1;
                        RES_DATA     <= old_val;
                        RES_EXC      <= MEM_ERR ? EXC_MEM_ERROR : EXC_NONE;
                        RES_WRITE_RD <= !MEM_ERR;
                        state        <= S_DONE;
                    end
                end
                S_DONE: begin
                    RES_WRITE_RD <= 1'b0;
                    IRQ_BLOCK    <= 1'b0;
                    state        <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Events and counters
    // ************************************************************
    logic [ST_W-1:0] ev;
    logic            rd_status;
    logic            wr_access;
    logic [7:0]      tab_idx;
    logic [ST_W-1:0] next_status;

    always_comb begin
        ev = '0;
        ev[ST_DONE]    = RES_VALID && (RES_EXC == EXC_NONE);
        ev[ST_EXC]     = RES_VALID && (RES_EXC != EXC_NONE) && (RES_EXC != EXC_MEM_ERROR);
        ev[ST_MEM_ERR] = RES_VALID && (RES_EXC == EXC_MEM_ERROR);
        rd_status = PSEL && PENABLE && !PWRITE && PREADY && (PADDR == OFF_STATUS);
        wr_access = PSEL && PENABLE && PWRITE && PREADY;
        tab_idx   = 8'((PADDR - OFF_SPACE_LO) >> 2);
        // Clear only what the read returned, or an event
        // landing between data capture and clear is lost
        next_status = (rd_status ? status & ~PRDATA[ST_W-1:0] : status) | ev;
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            status <= '0;
        end else begin
            // New event wins over the read clear
            status <= next_status;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            op_count <= 32'h0;
            last_exc <= EXC_NONE;
        end else if (RES_VALID) begin
            op_count <= op_count + 32'h1;
            last_exc <= RES_EXC;
        end
    end

    // ************************************************************
    // APB slave, one wait state
    // ************************************************************
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            mask <= MASK_RESET;
            for (int i = 0; i < 8; i++) begin
                space_tab[i] <= SPACE_RESET;
            end
        end else if (wr_access) begin
            if (PADDR == OFF_MASK) begin
                mask <= PWDATA[ST_W-1:0];
            end else if (PADDR >= OFF_SPACE_LO && PADDR <= OFF_SPACE_HI &&
                         PADDR[1:0] == 2'h0) begin
                space_tab[tab_idx[2:0]] <= PWDATA;
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            if (PSEL && PENABLE && !PREADY) begin
                PREADY <= 1'b1;
                PRDATA <= 32'h0;
                if (PADDR == OFF_STATUS) begin
                    PRDATA <= {29'h0, status};
                end else if (PADDR == OFF_MASK) begin
                    PRDATA <= {29'h0, mask};
                end else if (PADDR == OFF_LAST_EXC) begin
                    PRDATA <= {29'h0, last_exc};
                end else if (PADDR == OFF_COUNT) begin
                    PRDATA <= op_count;
                end else if (PADDR >= OFF_SPACE_LO && PADDR <= OFF_SPACE_HI &&
                             PADDR[1:0] == 2'h0) begin
                    PRDATA <= space_tab[tab_idx[2:0]];
                end else begin
                    PSLVERR <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(next_status & mask);
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_locked_read;
        MEM_VALID && MEM_READY && !MEM_REQ.write && MEM_REQ.lock;
    endsequence

    a_word_upper_zero: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        RES_VALID && RES_WRITE_RD && !cur.dword |-> RES_DATA[63:32] == 32'h0)
        else $error("word result upper half not zero");
    a_never_cc: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        !RES_WRITE_CC) else $error("condition codes written");
    a_store_follows: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        state == S_WAIT_RD && MEM_DONE && !MEM_ERR |=> ##1 MEM_VALID && MEM_REQ.write)
        else $error("no store after load");
    a_lock_held: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        s_locked_read |=> MEM_REQ.lock throughout (state == S_WAIT_RD)[*1])
        else $error("lock dropped after read");
    a_mismatch_keep: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        MEM_VALID && MEM_REQ.write && (cur.dword ? old_val != cur.cmp
        : old_val[31:0] != cur.cmp[31:0]) |-> MEM_REQ.wdata == old_val)
        else $error("mismatch changes memory");
    a_illegal_exc: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        state == S_CHECK && chk_illegal |=> RES_VALID && RES_EXC == EXC_ILLEGAL)
        else $error("illegal form not trapped");
    a_misalign_exc: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        state == S_CHECK && !chk_illegal && cur.dword && cur.addr[2:0] != 3'h0
        |=> RES_EXC == EXC_MISALIGN) else $error("misalign not trapped");
    a_priv_window: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        state == S_CHECK && cur.priv && !cur.hpriv && sel_space == 8'h30 &&
        !chk_illegal && !chk_misalign |=> RES_EXC == EXC_PRIV_ACTION)
        else $error("privileged window not trapped");
    a_user_bit: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        state == S_CHECK && !cur.priv && !cur.hpriv && !sel_space[7] &&
        !chk_illegal && !chk_misalign |=> RES_EXC == EXC_PRIV_ACTION)
        else $error("user space bit not checked");
    a_space_exc: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        state == S_CHECK && !chk_illegal && !chk_misalign && !chk_priv && chk_space
        |=> RES_VALID && RES_EXC == EXC_DATA_ACCESS)
        else $error("unlisted space not trapped");
    a_misalign_word: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        state == S_CHECK && !chk_illegal && !cur.dword && cur.addr[1:0] != 2'h0
        |=> RES_EXC == EXC_MISALIGN) else $error("word misalign not trapped");
    a_hyper_free: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        state == S_CHECK && cur.hpriv && !chk_illegal && !chk_misalign && !chk_space
        |=> state == S_READ) else $error("hyperprivileged access refused");
    a_exc_no_write: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        RES_VALID && RES_EXC != EXC_NONE |-> !RES_WRITE_RD)
        else $error("destination written on exception");

    // Memory traffic only inside the blocked, locked window
    a_mem_blocked: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        MEM_VALID |-> IRQ_BLOCK && MEM_REQ.lock) else $error("memory access not locked");
    a_word_store_hi: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        MEM_VALID && MEM_REQ.write && !MEM_REQ.dword |-> MEM_REQ.wdata[63:32] == 32'h0)
        else $error("word store upper half not zero");
    a_space_route: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        MEM_VALID && !cur.instr[INS_IMM_SEL]
        |-> MEM_REQ.space == cur.instr[INS_SPC_HI:INS_SPC_LO])
        else $error("immediate space not used");

endmodule : cas_unit
`default_nettype wire

// ===== test/cas_mem_model.sv
// Purpose: Memory partner for the compare-and-swap unit
// Assumes: Word array, low word at the lower address
// Notes:   Latency varies with the write count; stall comes from the bench
`timescale 1ns/1ps
`default_nettype none
module cas_mem_model
    import cas_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Request side
    input  wire logic        valid,
    input  wire mem_req_t    req,
    output var  logic        ready,
    output var  logic        done,
    output var  logic [63:0] rdata,
    output var  logic        err,
    // Bench control
    input  wire logic        stall,
    input  wire logic        err_wr
);
    logic [31:0] mem [0:7];
    int          writes;
    logic        busy;
    logic [1:0]  delay;
    mem_req_t    cur;
    logic [2:0]  idx;

    assign idx   = cur.addr[4:2];
    assign ready = !busy && !stall;

    // ************************************************************
    // Access engine
    // ************************************************************
    // Single port: nothing else can touch a line between read and write
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy   <= 1'b0;
            done   <= 1'b0;
            err    <= 1'b0;
            rdata  <= 64'h0;
            writes <= 0;
        end else begin
            done  <= 1'b0;
            err   <= 1'b0;
            // Stale data never looks valid
            rdata <= ~rdata;
            if (valid && ready) begin
                busy  <= 1'b1;
                cur   <= req;
                delay <= writes[1:0];
            end else if (busy && delay != 2'd0) begin
                delay <= delay - 2'd1;
            end else if (busy) begin
                busy  <= 1'b0;
                done  <= 1'b1;
                err   <= cur.write && err_wr;
                rdata <= cur.dword ? {mem[idx + 3'd1], mem[idx]} : {32'h0, mem[idx]};
                if (cur.write && !err_wr) begin
                    writes   <= writes + 1;
                    mem[idx] <= cur.wdata[31:0];
                    if (cur.dword)
                        mem[idx + 3'd1] <= cur.wdata[63:32];
                end
            end
        end
    end
endmodule : cas_mem_model
`default_nettype wire

// ===== test/atomic_compare_swap_unit_bench.sv
// Purpose: Self-checking bench for the compare-and-swap unit
// Assumes: One request at a time, bench is the APB master
// Notes:   Results checked against a queue of expected notes
`timescale 1ns/1ps
`default_nettype none
module atomic_compare_swap_unit_bench
    import cas_pkg::*;
;
    typedef struct {
        exc_t        exc;
        logic        wr;
        logic [63:0] data;
    } note_t;

    logic        CLK_SYS   = 1'b0;
    logic        RST_B     = 1'b0;
    logic        REQ_VALID = 1'b0;
    cas_req_t    REQ       = '0;
    logic        REQ_READY, RES_VALID, RES_WRITE_RD, RES_WRITE_CC, IRQ_BLOCK, IRQ;
    logic [63:0] RES_DATA, MEM_RDATA;
    exc_t        RES_EXC;
    logic        MEM_VALID, MEM_READY, MEM_DONE, MEM_ERR, PREADY, PSLVERR;
    mem_req_t    MEM_REQ;
    logic        PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [7:0]  PADDR  = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, q;
    logic        stall = 1'b0, err_wr = 1'b0, e, hp = 1'b0;
    logic [31:0] seed = 32'hd356dc9c;
    logic [63:0] a, b, x;
    note_t       notes[$];
    note_t       n;
    int          num_errors = 0, compares = 0, w0, ops = 0;

    always #2 CLK_SYS = ~CLK_SYS;

    cas_unit u_dut (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .REQ_VALID(REQ_VALID), .REQ(REQ),
        .REQ_READY(REQ_READY), .RES_VALID(RES_VALID), .RES_DATA(RES_DATA),
        .RES_WRITE_RD(RES_WRITE_RD), .RES_WRITE_CC(RES_WRITE_CC), .RES_EXC(RES_EXC),
        .IRQ_BLOCK(IRQ_BLOCK), .MEM_VALID(MEM_VALID), .MEM_REQ(MEM_REQ),
        .MEM_READY(MEM_READY), .MEM_DONE(MEM_DONE), .MEM_RDATA(MEM_RDATA),
        .MEM_ERR(MEM_ERR), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .IRQ(IRQ));

    cas_mem_model u_mem (.clk(CLK_SYS), .rst_b(RST_B), .valid(MEM_VALID), .req(MEM_REQ),
        .ready(MEM_READY), .done(MEM_DONE), .rdata(MEM_RDATA), .err(MEM_ERR),
        .stall(stall), .err_wr(err_wr));

    // ************************************************************
    // Helpers
    // ************************************************************
    function logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : rnd

    function logic [31:0] ins(input logic imm, input logic [7:0] sp);
        return {18'h0, imm, sp, 5'h0};
    endfunction : ins

    task chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task results();
        $display("mismatches %0d comparisons %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results

    task fail();
        chk(64'h1, 64'h0);
        results();
    endtask : fail

    task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int i;
        @(posedge CLK_SYS);
        PSEL    <= 1'b1;
        PWRITE  <= w;
        PADDR   <= ad;
        PWDATA  <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        i = 0;
        do begin
            @(posedge CLK_SYS);
            i++;
        end while (PREADY !== 1'b1 && i < 20);
        q = PRDATA;
        e = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
        if (i >= 20) fail();
    endtask : apb

    task cas(input logic dw, input logic [31:0] in, input logic [63:0] ad, c, s,
             input logic [7:0] sr, input logic pv, input exc_t ex, input logic [63:0] ed);
        int i;
        notes.push_back('{ex, ex == EXC_NONE, ed});
        ops++;
        @(posedge CLK_SYS);
        REQ_VALID <= 1'b1;
        REQ       <= '{dw, in, ad, c, s, sr, pv, hp};
        i = 0;
        do begin
            @(posedge CLK_SYS);
            i++;
        end while (REQ_READY !== 1'b1 && i < 50);
        if (i >= 50) fail();
        REQ_VALID <= 1'b0;
        i = 0;
        while (RES_VALID !== 1'b1 && i < 200) begin
            @(posedge CLK_SYS);
            i++;
        end
        if (i >= 200) fail();
        repeat (2) @(posedge CLK_SYS);
    endtask : cas

    task bad(input logic dw, input logic [31:0] in, input logic [63:0] ad,
             input logic [7:0] sr, input logic pv, input exc_t ex);
        cas(dw, in, ad, {rnd(), rnd()}, {rnd(), rnd()}, sr, pv, ex, 64'h0);
    endtask : bad

    // ************************************************************
    // Result watcher
    // ************************************************************
    always @(posedge CLK_SYS) begin
        stall <= ^rnd();
        if (RST_B === 1'b1 && RES_VALID === 1'b1) begin
            if (notes.size() == 0)
                chk(64'h1, 64'h0);
            else begin
                n = notes.pop_front();
                chk(RES_EXC, n.exc);
                chk(RES_WRITE_RD, n.wr);
                if (n.wr) chk(RES_DATA, n.data);
                chk(RES_WRITE_CC, 1'b0);
                chk(IRQ_BLOCK, 1'b1);
            end
        end
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (10) @(posedge CLK_SYS);
        RST_B <= 1'b1;
        repeat (2) @(posedge CLK_SYS);
        apb(1'b0, OFF_MASK, 32'h0);
        chk(q, MASK_RESET);
        apb(1'b0, OFF_SPACE_LO, 32'h0);
        chk(q, SPACE_RESET);
        apb(1'b0, 8'h30, 32'h0);
        chk({q, 31'h0, e}, 64'h1);
        // Permit spaces 04, 2f, 30, 7f and 80
        apb(1'b1, OFF_SPACE_LO, 32'h0000_0010);
        apb(1'b1, OFF_SPACE_LO + 8'h04, 32'h0001_8000);
        apb(1'b1, OFF_SPACE_LO + 8'h0c, 32'h8000_0000);
        apb(1'b1, OFF_SPACE_LO + 8'h10, 32'h0000_0001);
        apb(1'b0, OFF_SPACE_LO + 8'h04, 32'h0);
        chk(q, 32'h0001_8000);
        apb(1'b0, OFF_STATUS, 32'h0);
        apb(1'b1, OFF_MASK, 32'h1);
        $display("test registers done");
        a = {rnd(), rnd()};
        b = {rnd(), rnd()};
        u_mem.mem[0] = a[31:0];
        u_mem.mem[1] = a[63:32];
        cas(1'b1, ins(1'b0, 8'h80), 64'h0, a, b, 8'h00, 1'b0, EXC_NONE, a);
        chk({u_mem.mem[1], u_mem.mem[0]}, b);
        chk(IRQ, 1'b1);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(q, 32'h1);
        repeat (2) @(posedge CLK_SYS);
        chk(IRQ, 1'b0);
        w0 = u_mem.writes;
        cas(1'b1, ins(1'b0, 8'h80), 64'h0, b ^ 64'h8000_0000_0000_0000, a, 8'h00, 1'b0,
            EXC_NONE, b);
        chk({u_mem.mem[1], u_mem.mem[0]}, b);
        chk(u_mem.writes, w0 + 1);
        x = {rnd(), rnd()};
        cas(1'b0, ins(1'b0, 8'h80), 64'h4, {x[31:0], b[63:32]}, x, 8'h00, 1'b0,
            EXC_NONE, {32'h0, b[63:32]});
        chk({u_mem.mem[1], u_mem.mem[0]}, {x[31:0], b[31:0]});
        cas(1'b0, ins(1'b1, 8'h00), 64'h4, {32'h0, ~x[31:0]}, a, 8'h80, 1'b0,
            EXC_NONE, {32'h0, x[31:0]});
        chk({u_mem.mem[1], u_mem.mem[0]}, {x[31:0], b[31:0]});
        cas(1'b1, ins(1'b0, 8'h2f), 64'h0, {x[31:0], b[31:0]}, a, 8'h00, 1'b1,
            EXC_NONE, {x[31:0], b[31:0]});
        chk({u_mem.mem[1], u_mem.mem[0]}, a);
        // Hyperprivileged: space 30 passes the privilege checks
        hp = 1'b1;
        cas(1'b0, ins(1'b0, 8'h30), 64'h0, {32'h0, ~a[31:0]}, x, 8'h00, 1'b0,
            EXC_NONE, {32'h0, a[31:0]});
        hp = 1'b0;
        chk({u_mem.mem[1], u_mem.mem[0]}, a);
        $display("test data paths done");
        // Only the memory-error source may interrupt now
        apb(1'b1, OFF_MASK, 32'h4);
        w0 = u_mem.writes;
        bad(1'b1, ins(1'b1, 8'h01), 64'h0, 8'h80, 1'b0, EXC_ILLEGAL);
        bad(1'b1, ins(1'b1, 8'h80), 64'h0, 8'h80, 1'b0, EXC_ILLEGAL);
        bad(1'b1, ins(1'b0, 8'h80), 64'h4, 8'h00, 1'b0, EXC_MISALIGN);
        bad(1'b0, ins(1'b0, 8'h80), 64'h2, 8'h00, 1'b0, EXC_MISALIGN);
        bad(1'b0, ins(1'b0, 8'h04), 64'h0, 8'h00, 1'b0, EXC_PRIV_ACTION);
        bad(1'b0, ins(1'b0, 8'h30), 64'h0, 8'h00, 1'b1, EXC_PRIV_ACTION);
        bad(1'b0, ins(1'b0, 8'h7f), 64'h0, 8'h00, 1'b1, EXC_PRIV_ACTION);
        bad(1'b0, ins(1'b0, 8'h81), 64'h0, 8'h80, 1'b0, EXC_DATA_ACCESS);
        chk(u_mem.writes, w0);
        chk(IRQ, 1'b0);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(q[1], 1'b1);
        err_wr <= 1'b1;
        bad(1'b1, ins(1'b0, 8'h80), 64'h0, 8'h00, 1'b0, EXC_MEM_ERROR);
        err_wr <= 1'b0;
        chk(IRQ, 1'b1);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(q[2], 1'b1);
        apb(1'b0, OFF_LAST_EXC, 32'h0);
        chk(q, EXC_MEM_ERROR);
        apb(1'b0, OFF_COUNT, 32'h0);
        chk(q, ops);
        $display("test exceptions done");
        results();
    end
endmodule : atomic_compare_swap_unit_bench
`default_nettype wire
